/* verilog/pulse_tagger_defs.svh */
// constants for the gps pulse time tagger
// assumes inclusion by bare name from the package and the design modules
`ifndef PULSE_TAGGER_DEFS_SVH
`define PULSE_TAGGER_DEFS_SVH
`define CLK_PERIOD_NS      100
`define TICK_NS            100
`define TICK_CYCLES        ((`TICK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PULSE_CNT_W        16
`define OFFSET_W           32
`define SAMPLE_W           16
`define NUM_CHANNELS       6
`define CHAN_IDX_W         3
`define PULSE_CNT_RST      16'h0000
`define OFFSET_RST         32'h0000_0000
`endif

/* verilog/pulse_tagger_pkg.sv */
// types shared by the time tagger modules
// assumes the defs header is on the include path
`include "pulse_tagger_defs.svh"
package pulse_tagger_pkg;
  typedef logic [`SAMPLE_W-1:0]    sample_t;
  typedef logic [`OFFSET_W-1:0]    offset_t;
  typedef logic [`PULSE_CNT_W-1:0] pulse_cnt_t;
  typedef logic [`CHAN_IDX_W-1:0]  chan_t;
  typedef enum logic [1:0] {ST_IDLE, ST_CONVERT, ST_EMIT} seq_state_t;
endpackage

/* verilog/edge_time_if.sv */
// carries synchronized pulse time state from the edge unit to the tagger
// assumes a single clock domain
`timescale 1ns/100ps
`default_nettype none
interface edge_time_if;
  import pulse_tagger_pkg::*;
  pulse_cnt_t pulse_count;
  offset_t    offset;
  modport src (output pulse_count, output offset);
  modport dst (input pulse_count, input offset);
endinterface
`default_nettype wire

/* verilog/pulse_edge_timer.sv */
// synchroniser, edge detector, pulse counter and offset timer
// assumes the clock is the 10 MHz timebase
`include "pulse_tagger_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module pulse_edge_timer
  import pulse_tagger_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic ce_in,
  input  wire logic pulse_in,
  edge_time_if.src  et
);
  logic       sync1_q;
  logic       sync2_q;
  logic       prev_q;
  logic       armed_q;
  pulse_cnt_t count_q;
  offset_t    offset_q;
  wire        rise_w;
  // armed after a low level, so a line stuck high never counts
  assign rise_w = sync2_q & ~prev_q & armed_q;
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sync1_q  <= 1'b1;
      sync2_q  <= 1'b1;
      prev_q   <= 1'b1;
      armed_q  <= 1'b0;
      count_q  <= `PULSE_CNT_RST;
      offset_q <= `OFFSET_RST;
    end
    else if (ce_in)
    begin
      sync1_q <= pulse_in;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
      if (!sync2_q)
        armed_q <= 1'b1;
      if (rise_w)
        count_q <= count_q + 1'b1;
      // one count per 100 ns clock period
      if (rise_w)
        offset_q <= `OFFSET_RST;
      else if (offset_q != {`OFFSET_W{1'b1}})
        offset_q <= offset_q + 1'b1;
    end
  end
  assign et.pulse_count = count_q;
  assign et.offset      = offset_q;
endmodule
`default_nettype wire

/* verilog/gps_pulse_time_tagger.sv */
// top: sequences the shared converter and emits tagged measurement sets
// assumes a converter that returns one sample per request on the same clock
`include "pulse_tagger_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module gps_pulse_time_tagger
  import pulse_tagger_pkg::*;
#(
  parameter int NUM_CH = `NUM_CHANNELS
)
(
  input  wire logic                  CORE_CLK_IN,
  input  wire logic                  RST_N_IN,
  input  wire logic                  CE_IN,
  input  wire logic                  GPS_TIMING_PULSE_IN,
  input  wire logic                  SAMPLE_START_IN,
  input  wire logic                  ADC_VALID_IN,
  input  wire logic [`SAMPLE_W-1:0]  ADC_DATA_IN,
  output logic                       ADC_REQ_OUT,
  output logic [`CHAN_IDX_W-1:0]     ADC_CHAN_OUT,
  output logic                       SET_VALID_OUT,
  output logic [`SAMPLE_W*NUM_CH-1:0] SET_DATA_OUT,
  output logic [`OFFSET_W-1:0]       OFFSET_OUT,
  output logic [`PULSE_CNT_W-1:0]    PULSE_COUNT_OUT
);
  edge_time_if et ();
  seq_state_t state_q;
  seq_state_t state_d;
  chan_t      chan_q;
  offset_t    tag_offset_q;
  pulse_cnt_t tag_count_q;
  sample_t    samples_q [NUM_CH];
  wire        last_ch_w;
  wire        start_w;
  pulse_edge_timer u_edge (
    .clk_in   (CORE_CLK_IN),
    .rst_n_in (RST_N_IN),
    .ce_in    (CE_IN),
    .pulse_in (GPS_TIMING_PULSE_IN),
    .et       (et)
  );
  assign last_ch_w = (chan_q == chan_t'(NUM_CH - 1));
  assign start_w   = (state_q == ST_IDLE) && SAMPLE_START_IN;
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:    if (SAMPLE_START_IN) state_d = ST_CONVERT;
      ST_CONVERT: if (ADC_VALID_IN && last_ch_w) state_d = ST_EMIT;
      ST_EMIT:    state_d = ST_IDLE;
      default:    state_d = ST_IDLE;
    endcase
  end
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      state_q      <= ST_IDLE;
      chan_q       <= '0;
      tag_offset_q <= `OFFSET_RST;
      tag_count_q  <= `PULSE_CNT_RST;
    end
    else if (CE_IN)
    begin
      state_q <= state_d;
      // latch at sampling start so the tag ignores transmit delay
      if (start_w)
      begin
        tag_offset_q <= et.offset;
        tag_count_q  <= et.pulse_count;
        chan_q       <= '0;
      end
      else if (state_q == ST_CONVERT && ADC_VALID_IN && !last_ch_w)
        chan_q <= chan_q + 1'b1;
    end
  end
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++)
    begin : g_smp
      always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN)
      begin
        if (!RST_N_IN)
          samples_q[g] <= '0;
        else if (CE_IN && state_q == ST_CONVERT && ADC_VALID_IN
                 && chan_q == chan_t'(g))
          samples_q[g] <= ADC_DATA_IN;
      end
    end
  endgenerate
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      ADC_REQ_OUT     <= 1'b0;
      ADC_CHAN_OUT    <= '0;
      SET_VALID_OUT   <= 1'b0;
      SET_DATA_OUT    <= '0;
      OFFSET_OUT      <= `OFFSET_RST;
      PULSE_COUNT_OUT <= `PULSE_CNT_RST;
    end
    else if (CE_IN)
    begin
      ADC_REQ_OUT   <= (state_d == ST_CONVERT);
      ADC_CHAN_OUT  <= (state_d == ST_CONVERT && !start_w && ADC_VALID_IN)
                       ? chan_q + 1'b1 : (start_w ? '0 : chan_q);
      SET_VALID_OUT <= (state_q == ST_EMIT);
      if (state_q == ST_EMIT)
      begin
        for (int i = 0; i < NUM_CH; i++)
          SET_DATA_OUT[i*`SAMPLE_W +: `SAMPLE_W] <= samples_q[i];
        OFFSET_OUT      <= tag_offset_q;
        PULSE_COUNT_OUT <= tag_count_q;
      end
    end
  end
endmodule
`default_nettype wire

/* tb/gps_pulse_time_tagger_checker.sv */
// checker for request, channel and set relations at the top ports
// assumes six channels and the clock enable held high
`timescale 1ns/100ps
`default_nettype none
module gps_pulse_time_tagger_checker (
  input wire logic        CORE_CLK_IN,
  input wire logic        RST_N_IN,
  input wire logic        SAMPLE_START_IN,
  input wire logic        ADC_VALID_IN,
  input wire logic        ADC_REQ_OUT,
  input wire logic [2:0]  ADC_CHAN_OUT,
  input wire logic        SET_VALID_OUT,
  input wire logic [15:0] PULSE_COUNT_OUT
);
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  wire step = ADC_REQ_OUT && ADC_VALID_IN;
  AST_REQ_START: assert property (
    $rose(ADC_REQ_OUT) |-> ADC_CHAN_OUT == 3'h0 && $past(SAMPLE_START_IN)) else $error("bad start");
  AST_CHAN_STEP: assert property (
    step && ADC_CHAN_OUT < 3'h5 |=> ADC_REQ_OUT && ADC_CHAN_OUT == $past(ADC_CHAN_OUT) + 3'h1)
    else $error("bad channel step");
  AST_REQ_HOLD: assert property (
    ADC_REQ_OUT && !ADC_VALID_IN |=> ADC_REQ_OUT && $stable(ADC_CHAN_OUT)) else $error("req dropped");
  AST_LAST_CHAN: assert property (
    step && ADC_CHAN_OUT == 3'h5 |=> !ADC_REQ_OUT ##1 SET_VALID_OUT) else $error("no set");
  AST_SET_ONE: assert property (
    SET_VALID_OUT |=> !SET_VALID_OUT) else $error("set too long");
  AST_SET_CAUSE: assert property (
    $rose(SET_VALID_OUT) |-> $past(ADC_REQ_OUT, 2) && !$past(ADC_REQ_OUT)) else $error("stray set");
  AST_CNT_STEP: assert property (
    $changed(PULSE_COUNT_OUT) |-> SET_VALID_OUT)
    else $error("count changed outside a set");
endmodule
bind gps_pulse_time_tagger gps_pulse_time_tagger_checker chk_u (.*);
`default_nettype wire

/* tb/gps_pulse_model.sv */
// receiver model: pulse pin, pulled high when idle
// assumes pulses are spaced far apart
`timescale 1ns/100ps
`default_nettype none
module gps_pulse_model (
  input  wire logic clk_in,
  output logic      pin_out
);
  initial pin_out = 1'b1;
  task automatic fire(input int low);
    @(posedge clk_in) pin_out <= 1'b0;
    repeat (low) @(posedge clk_in);
    pin_out <= 1'b1;
  endtask
endmodule
`default_nettype wire

/* tb/gps_pulse_time_tagger_test.sv */
// testbench: pulses, set requests and a random converter
// assumes design, checker and model compiled first
`timescale 1ns/100ps
`default_nettype none
module gps_pulse_time_tagger_test;
  import pulse_tagger_pkg::*;
  logic clk = 0, rst_n = 0, start = 0, vld = 0, req, set_v, pin;
  sample_t din = '0;
  logic [95:0] sd, acc;
  offset_t off, last_off;
  pulse_cnt_t cnt, qc[$];
  int fails = 0, num_checks = 0, cyc = 0, ts = 0, t0, vi = 0, qd[$];
  initial forever #50 clk = ~clk;
  gps_pulse_model gps_u (.clk_in(clk), .pin_out(pin));
  gps_pulse_time_tagger dut_u (.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(1'b1),
    .GPS_TIMING_PULSE_IN(pin), .SAMPLE_START_IN(start), .ADC_VALID_IN(vld),
    .ADC_DATA_IN(din), .ADC_REQ_OUT(req), .ADC_CHAN_OUT(), .SET_VALID_OUT(set_v),
    .SET_DATA_OUT(sd), .OFFSET_OUT(off), .PULSE_COUNT_OUT(cnt));
  task automatic check(input logic [95:0] a, input logic [95:0] e);
    num_checks++;
    if (a !== e)
    begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, a, e);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // mode 0 skips offset, 1 expects a fresh offset, 2 expects start spacing
  task automatic do_set(input int m, input pulse_cnt_t c);
    int n;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    qc.push_back(c);
    qd.push_back(m == 2 ? cyc - ts : m - 1);
    ts = cyc;
    for (n = 0; n < 60 && !set_v; n++) @(posedge clk);
    if (!set_v) begin fails++; print_verdict(); end
    @(posedge clk);
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    vld <= req && !vld && 1'($urandom_range(1));
    din <= sample_t'($urandom);
    if (vld && req)
    begin
      acc[16*vi +: 16] <= din;
      vi <= (vi + 1) % 6;
    end
    if (set_v)
    begin
      check(sd, acc);
      check(96'(cnt), 96'(qc.pop_front()));
      t0 = qd.pop_front();
      if (t0 == 0) check(96'(off <= 32'h8), 96'h1);
      else if (t0 > 0) check(96'(off), 96'(last_off + offset_t'(t0)));
      last_off = off;
    end
  end
  initial
  begin
    void'($urandom(13232));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    do_set(0, 16'h0);
    for (int k = 1; k <= 3; k++)
    begin
      gps_u.fire(2 + k);
      repeat (4) @(posedge clk);
      do_set(1, pulse_cnt_t'(k));
      repeat ($urandom_range(30, 2)) @(posedge clk);
      do_set(2, pulse_cnt_t'(k));
    end
    repeat (5) @(posedge clk);
    print_verdict();
  end
endmodule
`default_nettype wire
